// ==== rtl/dpm_mailbox.v ====
// Dual-port mailbox: two 36-bit mail registers, pin ports A and B, APB registers
// Function
// R1 - Two 36-bit mail registers, one per direction
// R2 - Mail select high picks mail, low picks queue
// R3 - Port A mail write loads first register
// R4 - Port B mail write loads second register
// R5 - Accepted write drives mail-full flag low
// R6 - Writes ignored while mail-full flag low
// R7 - Enabled outputs show queue or mail register
// R8 - Port B mail read releases first flag
// R9 - Port A mail read releases second flag
// R10 - Reading leaves mail contents unchanged
// R11 - Controller qualifies transfers with select, direction, enable
`timescale 1ns/1ps
`include "dpm_defs.vh"
module dpm_mailbox (
  input wire clk, // 20 MHz system clock
  input wire rst_n, // Asynchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction, high for write
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error on unmapped address
  output wire irq, // Level interrupt, high while an enabled event is pending
  input wire porta_clock, // Port A clock pin
  input wire porta_chip_select_n, // Port A chip select, active low
  input wire porta_direction, // Port A direction, high writes
  input wire porta_enable, // Port A enable, active high
  input wire porta_mail_select, // Port A mail select
  input wire [35:0] porta_data_i, // Port A data pins in
  output wire [35:0] porta_data_o, // Port A data pins out
  output wire porta_data_oe, // Port A output enable
  input wire [35:0] porta_queue_data, // Queue output word for port A
  output wire a_to_b_mail_full_n, // First mail register full, active low
  input wire portb_clock, // Port B clock pin
  input wire portb_chip_select_n, // Port B chip select, active low
  input wire portb_direction, // Port B direction, low writes
  input wire portb_enable, // Port B enable, active high
  input wire portb_mail_select, // Port B mail select
  input wire [35:0] portb_data_i, // Port B data pins in
  output wire [35:0] portb_data_o, // Port B data pins out
  output wire portb_data_oe, // Port B output enable
  input wire [35:0] portb_queue_data, // Queue output word for port B
  output wire b_to_a_mail_full_n // Second mail register full, active low
);
  wire [`DPM_SYNC_W-1:0] a_sync;
  wire [`DPM_SYNC_W-1:0] b_sync;
  reg a_clk_prev_q;
  reg b_clk_prev_q;
  reg [35:0] a_to_b_mail_reg_q;
  reg [35:0] b_to_a_mail_reg_q;
  reg a_to_b_full_q;
  reg b_to_a_full_q;
  reg [1:0] ctrl_q;
  reg [5:0] int_stat_q;
  reg [5:0] int_stat_d;
  reg [5:0] int_en_q;
  reg [31:0] prdata_q;
  reg pslverr_q;
  reg [31:0] rd_mux;
  reg rd_hit;
  reg [35:0] a_out_q;
  reg [35:0] b_out_q;
  reg a_oe_q;
  reg b_oe_q;

  // All pin inputs of each port cross together, so clock and controls stay aligned
  dpm_pin_sync #(.W(`DPM_SYNC_W)) u_sync_a (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({porta_clock, ~porta_chip_select_n, porta_direction, porta_enable, porta_mail_select, porta_data_i}),
    .sync_out(a_sync)
  );

  dpm_pin_sync #(.W(`DPM_SYNC_W)) u_sync_b (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({portb_clock, ~portb_chip_select_n, portb_direction, portb_enable, portb_mail_select, portb_data_i}),
    .sync_out(b_sync)
  );

  // Unpacked synchronised pins; selects cross inverted so a cleared stage reads as deselected
  wire a_clk_s = a_sync[40];
  wire a_cs_n_s = ~a_sync[39];
  wire a_dir_s = a_sync[38];
  wire a_en_s = a_sync[37];
  wire a_mb_s = a_sync[36];
  wire [35:0] a_dat_s = a_sync[35:0];
  wire b_clk_s = b_sync[40];
  wire b_cs_n_s = ~b_sync[39];
  wire b_dir_s = b_sync[38];
  wire b_en_s = b_sync[37];
  wire b_mb_s = b_sync[36];
  wire [35:0] b_dat_s = b_sync[35:0];

  // Port clock edge detect on the synchronised copy; pin clocks must stay well below clk
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_clk_prev_q <= 1'b0;
      b_clk_prev_q <= 1'b0;
    end else begin
      a_clk_prev_q <= a_clk_s;
      b_clk_prev_q <= b_clk_s;
    end
  end

  wire a_rise = a_clk_s & ~a_clk_prev_q;
  wire b_rise = b_clk_s & ~b_clk_prev_q;

  // Transfer qualification by chip select, enable and port gate bit
  wire a_sel = a_rise & ~a_cs_n_s & a_en_s & ctrl_q[`DPM_CTRL_A_EN]; // [R11]
  wire b_sel = b_rise & ~b_cs_n_s & b_en_s & ctrl_q[`DPM_CTRL_B_EN]; // [R11]
  wire a_is_wr = (a_dir_s == `DPM_A_WRITE_LVL);
  wire b_is_wr = (b_dir_s == `DPM_B_WRITE_LVL);

  // Low mail select leaves the transfer to the queue
  wire a_mail_wr = a_sel & a_mb_s & a_is_wr; // [R2]
  wire a_mail_rd = a_sel & a_mb_s & ~a_is_wr; // [R2]
  wire b_mail_wr = b_sel & b_mb_s & b_is_wr; // [R2]
  wire b_mail_rd = b_sel & b_mb_s & ~b_is_wr; // [R2]

  // A write is taken only into an empty mail register
  wire a_wr_take = a_mail_wr & ~a_to_b_full_q; // [R6]
  wire b_wr_take = b_mail_wr & ~b_to_a_full_q; // [R6]

  // Mail storage changes only on an accepted write, never on a read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_to_b_mail_reg_q <= `DPM_MAIL_RST;
      b_to_a_mail_reg_q <= `DPM_MAIL_RST;
    end else begin
      if (a_wr_take) begin
        a_to_b_mail_reg_q <= a_dat_s; // [R1] [R3] [R10]
      end
      if (b_wr_take) begin
        b_to_a_mail_reg_q <= b_dat_s; // [R1] [R4] [R10]
      end
    end
  end

  // Full flags: set by a write, released by the far port's read; set wins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_to_b_full_q <= 1'b0;
      b_to_a_full_q <= 1'b0;
    end else begin
      if (a_wr_take) begin
        a_to_b_full_q <= 1'b1; // [R5]
      end else if (b_mail_rd) begin
        a_to_b_full_q <= 1'b0; // [R8]
      end
      if (b_wr_take) begin
        b_to_a_full_q <= 1'b1; // [R5]
      end else if (a_mail_rd) begin
        b_to_a_full_q <= 1'b0; // [R9]
      end
    end
  end

  assign a_to_b_mail_full_n = ~a_to_b_full_q; // [R5]
  assign b_to_a_mail_full_n = ~b_to_a_full_q; // [R5]

  // Output drive: enabled while selected for read; mux picks queue or mail
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_out_q <= `DPM_MAIL_RST;
      b_out_q <= `DPM_MAIL_RST;
      a_oe_q <= 1'b0;
      b_oe_q <= 1'b0;
    end else begin
      a_oe_q <= ~a_cs_n_s & ~a_is_wr & ctrl_q[`DPM_CTRL_A_EN];
      b_oe_q <= ~b_cs_n_s & ~b_is_wr & ctrl_q[`DPM_CTRL_B_EN];
      a_out_q <= a_mb_s ? b_to_a_mail_reg_q : porta_queue_data; // [R7]
      b_out_q <= b_mb_s ? a_to_b_mail_reg_q : portb_queue_data; // [R7]
    end
  end

  assign porta_data_o = a_out_q;
  assign portb_data_o = b_out_q;
  assign porta_data_oe = a_oe_q;
  assign portb_data_oe = b_oe_q;

  // APB decode; no wait states
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // Read mux and address hit check
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      `DPM_OFF_CTRL: rd_mux = {30'h00000000, ctrl_q};
      `DPM_OFF_STATUS: rd_mux = {30'h00000000, b_to_a_full_q, a_to_b_full_q};
      `DPM_OFF_A2B_LO: rd_mux = a_to_b_mail_reg_q[31:0];
      `DPM_OFF_A2B_HI: rd_mux = {28'h0000000, a_to_b_mail_reg_q[35:32]};
      `DPM_OFF_B2A_LO: rd_mux = b_to_a_mail_reg_q[31:0];
      `DPM_OFF_B2A_HI: rd_mux = {28'h0000000, b_to_a_mail_reg_q[35:32]};
      `DPM_OFF_INT_STAT: rd_mux = {26'h0000000, int_stat_q};
      `DPM_OFF_INT_EN: rd_mux = {26'h0000000, int_en_q};
      `DPM_OFF_INT_CLR: rd_mux = 32'h00000000;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data and error captured in the setup cycle, shown in the access cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q <= pwrite ? 32'h00000000 : rd_mux;
      pslverr_q <= ~rd_hit;
    end
  end

  // Writable registers: port gates and interrupt enable
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `DPM_CTRL_RST;
      int_en_q <= `DPM_INT_EN_RST;
    end else if (apb_wr) begin
      if (paddr == `DPM_OFF_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end
      if (paddr == `DPM_OFF_INT_EN) begin
        int_en_q <= pwdata[5:0];
      end
    end
  end

  // Sticky events; a new event in the clearing cycle survives the clear
  wire [5:0] ev;
  assign ev[`DPM_EV_A2B_WR] = a_wr_take;
  assign ev[`DPM_EV_A2B_RD] = b_mail_rd;
  assign ev[`DPM_EV_B2A_WR] = b_wr_take;
  assign ev[`DPM_EV_B2A_RD] = a_mail_rd;
  assign ev[`DPM_EV_A_DROP] = a_mail_wr & a_to_b_full_q;
  assign ev[`DPM_EV_B_DROP] = b_mail_wr & b_to_a_full_q;

  always @* begin
    int_stat_d = int_stat_q;
    if (apb_wr && (paddr == `DPM_OFF_INT_CLR)) begin
      int_stat_d = int_stat_d & ~pwdata[5:0];
    end
    int_stat_d = int_stat_d | ev;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_q <= 6'h00;
    end else begin
      int_stat_q <= int_stat_d;
    end
  end

  assign irq = |(int_stat_q & int_en_q);
endmodule // dpm_mailbox

// ==== rtl/dpm_defs.vh ====
// Constants for the dual-port mailbox: register offsets, fields, resets
`ifndef DPM_DEFS_VH
`define DPM_DEFS_VH

`define DPM_DATA_W 36
`define DPM_SYNC_W 41

// APB register byte offsets
`define DPM_OFF_CTRL 8'h00
`define DPM_OFF_STATUS 8'h04
`define DPM_OFF_A2B_LO 8'h08
`define DPM_OFF_A2B_HI 8'h0C
`define DPM_OFF_B2A_LO 8'h10
`define DPM_OFF_B2A_HI 8'h14
`define DPM_OFF_INT_STAT 8'h18
`define DPM_OFF_INT_EN 8'h1C
`define DPM_OFF_INT_CLR 8'h20

// Control fields and reset value
`define DPM_CTRL_A_EN 0
`define DPM_CTRL_B_EN 1
`define DPM_CTRL_RST 2'h3

// Event bit positions in status, enable and clear registers
`define DPM_EV_A2B_WR 0
`define DPM_EV_A2B_RD 1
`define DPM_EV_B2A_WR 2
`define DPM_EV_B2A_RD 3
`define DPM_EV_A_DROP 4
`define DPM_EV_B_DROP 5
`define DPM_EV_W 6

// Direction level that means write on each port
`define DPM_A_WRITE_LVL 1'b1
`define DPM_B_WRITE_LVL 1'b0

// Reset values
`define DPM_MAIL_RST 36'h000000000
`define DPM_INT_EN_RST 6'h00

`endif

// ==== rtl/dpm_pin_sync.v ====
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module dpm_pin_sync #(
  parameter W = 1
) (
  input wire clk, // System clock
  input wire rst_n, // Asynchronous reset, active low
  input wire [W-1:0] async_in, // Pins from outside the clock domain
  output wire [W-1:0] sync_out // Synchronised copy
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // dpm_pin_sync

// ==== tb/dpm_mailbox_assertions.sv ====
// Checker for mail flags, port A output enable and APB ready of the mailbox
`timescale 1ns/1ps
`include "dpm_defs.vh"
module dpm_mailbox_assertions (
  input wire clk, // Clock
  input wire rst_n, // Reset, active low
  input wire pready, // APB ready
  input wire porta_clock, // Port A clock pin
  input wire porta_chip_select_n, // Port A select
  input wire porta_direction, // Port A direction
  input wire porta_mail_select, // Port A mail select
  input wire [35:0] porta_data_o, // Port A data out
  input wire porta_data_oe, // Port A output enable
  input wire [35:0] porta_queue_data, // Port A queue word
  input wire a_to_b_mail_full_n, // First flag
  input wire portb_clock, // Port B clock pin
  input wire portb_mail_select, // Port B mail select
  input wire b_to_a_mail_full_n // Second flag
);
  reg [2:0] up_q;
  // Synchronisers show stale zeros just after reset, so enables wait
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_q <= 3'h0;
    else if (up_q != 3'h4) up_q <= up_q + 3'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pready_one: assert property (pready) else $error("pready low");
  a_a2b_fill: assert property ($fell(a_to_b_mail_full_n) |->
    $past(porta_clock, 3) && !$past(porta_clock, 4) && $past(porta_mail_select, 3)) else $error("a2b fill");
  a_a2b_free: assert property ($rose(a_to_b_mail_full_n) |->
    $past(portb_clock, 3) && !$past(portb_clock, 4) && $past(portb_mail_select, 3)) else $error("a2b free");
  a_b2a_fill: assert property ($fell(b_to_a_mail_full_n) |->
    $past(portb_clock, 3) && !$past(portb_clock, 4) && $past(portb_mail_select, 3)) else $error("b2a fill");
  a_b2a_free: assert property ($rose(b_to_a_mail_full_n) |->
    $past(porta_clock, 3) && !$past(porta_clock, 4) && $past(porta_mail_select, 3)) else $error("b2a free");
  a_oe_cause: assert property (up_q == 3'h4 && porta_data_oe |-> !$past(porta_chip_select_n, 3) &&
    $past(porta_direction, 3) != `DPM_A_WRITE_LVL) else $error("oe cause");
  a_oe_follow: assert property (up_q == 3'h4 && !$past(porta_chip_select_n, 3) &&
    $past(porta_direction, 3) != `DPM_A_WRITE_LVL |-> porta_data_oe) else $error("oe follow");
  a_queue_path: assert property (up_q == 3'h4 && porta_data_oe && !$past(porta_mail_select, 3) |->
    porta_data_o == $past(porta_queue_data)) else $error("queue path");
  // While the second register stays full its word cannot change, so port A mail output holds
  a_b2a_kept: assert property (up_q == 3'h4 && $past(porta_mail_select, 3) && $past(porta_mail_select, 4) &&
    !$past(b_to_a_mail_full_n, 2) |-> $stable(porta_data_o)) else $error("b2a kept");
  cover property ($fell(a_to_b_mail_full_n));
  cover property ($fell(b_to_a_mail_full_n));
  cover property (porta_data_oe && !porta_mail_select);
endmodule // dpm_mailbox_assertions

// ==== tb/dpm_port_model.sv ====
// Port controller model driving the pin ports A (index 0) and B (index 1)
`timescale 1ns/1ps
module dpm_port_model (
  input wire clk, // System clock
  input wire [35:0] a_wire, // Resolved port A wire
  input wire [35:0] b_wire, // Resolved port B wire
  output reg [1:0] pclk, // Port clocks
  output reg [1:0] cs_n, // Selects, active low
  output reg [1:0] dir, // Direction levels
  output reg [1:0] en, // Enables
  output reg [1:0] ms, // Mail selects
  output reg [35:0] a_drv, // Port A drive
  output reg [35:0] b_drv // Port B drive
);
  initial begin
    pclk = 2'h0;
    cs_n = 2'h3;
    dir = 2'h2;
    en = 2'h0;
    ms = 2'h0;
    a_drv = 36'h000000000;
    b_drv = 36'h000000000;
  end
  // Controls stand 4 clk around the rise, beyond the 3 clk sync margin
  task automatic xfer(input int p, input bit wr, input bit sel, input [35:0] d, output [35:0] q);
    @(posedge clk);
    cs_n[p] <= 1'b0;
    en[p] <= 1'b1;
    ms[p] <= sel;
    dir[p] <= wr ^ p[0]; // A writes high, B writes low
    if (wr && p == 0) a_drv <= d;
    if (wr && p == 1) b_drv <= d;
    repeat (4) @(posedge clk);
    pclk[p] <= 1'b1;
    repeat (4) @(posedge clk);
    q = (p == 0) ? a_wire : b_wire;
    pclk[p] <= 1'b0;
    repeat (4) @(posedge clk);
    cs_n[p] <= 1'b1;
    en[p] <= 1'b0;
    // Released lines show the inverse so stale data cannot pass
    if (p == 0) a_drv <= ~a_drv;
    else b_drv <= ~b_drv;
  endtask
endmodule // dpm_port_model

// ==== tb/testbench.sv ====
// Testbench for the dual-port mailbox
`timescale 1ns/1ps
`include "dpm_defs.vh"
module testbench;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h00000000;
  reg [35:0] qa = 36'hA5A5A5A5A;
  reg [35:0] qb = 36'h5A5A5A5A5;
  wire [31:0] prdata;
  wire pready, pslverr, irq, a_oe, b_oe, a_fn, b_fn;
  wire [1:0] pclk, cs_n, dir, en, ms;
  wire [35:0] a_drv, b_drv, a_o, b_o, a_w, b_w;
  integer failures = 0;
  integer comparisons = 0;
  reg [31:0] rd;
  reg er;
  reg [35:0] q;
  always #25 clk = ~clk;
  // Wire level from the mailbox output enable; the model drives it otherwise
  assign a_w = a_oe ? a_o : a_drv;
  assign b_w = b_oe ? b_o : b_drv;
  dpm_mailbox u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .porta_clock(pclk[0]),
    .porta_chip_select_n(cs_n[0]), .porta_direction(dir[0]), .porta_enable(en[0]), .porta_mail_select(ms[0]),
    .porta_data_i(a_w), .porta_data_o(a_o), .porta_data_oe(a_oe), .porta_queue_data(qa), .a_to_b_mail_full_n(a_fn),
    .portb_clock(pclk[1]), .portb_chip_select_n(cs_n[1]), .portb_direction(dir[1]), .portb_enable(en[1]),
    .portb_mail_select(ms[1]), .portb_data_i(b_w), .portb_data_o(b_o), .portb_data_oe(b_oe),
    .portb_queue_data(qb), .b_to_a_mail_full_n(b_fn));
  dpm_port_model u_pm (.clk(clk), .a_wire(a_w), .b_wire(b_w), .pclk(pclk), .cs_n(cs_n), .dir(dir), .en(en),
    .ms(ms), .a_drv(a_drv), .b_drv(b_drv));
  task check(input [35:0] seen, input [35:0] exp, input [95:0] name);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("unexpected %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // APB cycle; waits on pready, the watchdog ends a hang
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task t_reset;
    begin
      apb(1'b0, `DPM_OFF_CTRL, 32'h00000000);
      check(rd, `DPM_CTRL_RST, "ctrl");
      check({a_fn, b_fn, irq}, 3'h6, "flags");
      apb(1'b0, `DPM_OFF_INT_EN, 32'h00000000);
      check(rd, `DPM_INT_EN_RST, "int en rst");
      apb(1'b0, 8'h40, 32'h00000000);
      check(er, 1'b1, "slverr");
      $display("test reset done");
    end
  endtask
  task t_a2b;
    begin
      apb(1'b1, `DPM_OFF_INT_EN, 32'h00000013);
      u_pm.xfer(0, 1'b1, 1'b1, 36'h912345678, q);
      check(a_fn, 1'b0, "a2b full");
      check(irq, 1'b1, "irq");
      apb(1'b0, `DPM_OFF_A2B_HI, 32'h00000000);
      check(rd, 32'h00000009, "a2b hi");
      u_pm.xfer(0, 1'b1, 1'b1, 36'h6EDCBA987, q);
      apb(1'b0, `DPM_OFF_A2B_LO, 32'h00000000);
      check(rd, 32'h12345678, "a2b kept");
      u_pm.xfer(1, 1'b0, 1'b1, 36'h000000000, q);
      check(q, 36'h912345678, "b read");
      check(a_fn, 1'b1, "a2b free");
      apb(1'b0, `DPM_OFF_A2B_LO, 32'h00000000);
      check(rd, 32'h12345678, "a2b intact");
      apb(1'b0, `DPM_OFF_INT_STAT, 32'h00000000);
      check(rd, 32'h00000013, "int stat");
      apb(1'b1, `DPM_OFF_INT_CLR, 32'h0000003F);
      @(posedge clk);
      check(irq, 1'b0, "irq clr");
      $display("test a2b done");
    end
  endtask
  task t_b2a;
    begin
      u_pm.xfer(1, 1'b1, 1'b1, 36'hC0FFEE123, q);
      check(b_fn, 1'b0, "b2a full");
      check(irq, 1'b0, "irq masked");
      apb(1'b0, `DPM_OFF_STATUS, 32'h00000000);
      check(rd, 32'h00000002, "status b2a");
      apb(1'b0, `DPM_OFF_B2A_LO, 32'h00000000);
      check(rd, 32'h0FFEE123, "b2a lo");
      apb(1'b0, `DPM_OFF_B2A_HI, 32'h00000000);
      check(rd, 32'h0000000C, "b2a hi");
      u_pm.xfer(0, 1'b0, 1'b1, 36'h000000000, q);
      check(q, 36'hC0FFEE123, "a read");
      check(b_fn, 1'b1, "b2a free");
      $display("test b2a done");
    end
  endtask
  // Port A switched off: a mail write must leave flag and word alone
  task t_gate;
    begin
      apb(1'b1, `DPM_OFF_CTRL, 32'h00000002);
      apb(1'b0, `DPM_OFF_CTRL, 32'h00000000);
      check(rd, 32'h00000002, "ctrl wr");
      u_pm.xfer(0, 1'b1, 1'b1, 36'h0AAAAAAAA, q);
      check(a_fn, 1'b1, "a gated");
      apb(1'b0, `DPM_OFF_A2B_LO, 32'h00000000);
      check(rd, 32'h12345678, "a2b gated");
      apb(1'b0, `DPM_OFF_STATUS, 32'h00000000);
      check(rd, 32'h00000000, "status 0");
      apb(1'b1, `DPM_OFF_CTRL, 32'h00000003);
      $display("test gate done");
    end
  endtask
  task t_queue;
    begin
      u_pm.xfer(0, 1'b1, 1'b0, 36'h111111111, q);
      check(a_fn, 1'b1, "queue wr");
      u_pm.xfer(0, 1'b0, 1'b0, 36'h000000000, q);
      check(q, qa, "a queue");
      u_pm.xfer(1, 1'b0, 1'b0, 36'h000000000, q);
      check(q, qb, "b queue");
      $display("test queue done");
    end
  endtask
  task conclude;
    begin
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_a2b;
    t_b2a;
    t_gate;
    t_queue;
    conclude;
  end
  // Tests need about 200 cycles; this allows twenty times that
  initial begin
    #200000;
    failures = failures + 1;
    conclude;
  end
endmodule // testbench
bind dpm_mailbox dpm_mailbox_assertions u_chk (.clk(clk), .rst_n(rst_n), .pready(pready),
  .porta_clock(porta_clock), .porta_chip_select_n(porta_chip_select_n), .porta_direction(porta_direction),
  .porta_mail_select(porta_mail_select), .porta_data_o(porta_data_o), .porta_data_oe(porta_data_oe),
  .porta_queue_data(porta_queue_data), .a_to_b_mail_full_n(a_to_b_mail_full_n), .portb_clock(portb_clock),
  .portb_mail_select(portb_mail_select), .b_to_a_mail_full_n(b_to_a_mail_full_n));
